// *** hw/qfd_top.sv ***
// Command decoder and read sequencer of a quad serial flash, link side and status side.
// Assumes the host keeps chip select high while idle and that sck stops outside frames.
//
// Operation
// - Quad reset opcode returns to single-bit protocol or leaves continuous read.
// - In continuous read, first quad reset only re-enables opcodes; second one reverts.
// - Single-bit framing ignores the upper three data lines.
// - After power-up the decoder uses single-bit opcode framing.
// - Single-bit fast read: opcode, 24-bit address, dummy byte, then data.
// - Quad fast read: opcode, three address, one mode, two dummy cycles, MSN first.
// - Linear reads drive on falling edges, increment, wrap past top to zero.
// - Bytes inside a read-locked block stream out as zero.
// - Mode upper nibble A makes the next frame start with address, no opcode.
// - Any other mode value makes the next frame start with an opcode.
// - Quad-output read: single-line opcode, address, dummy byte, data on four lines.
// - Quad I/O read: single-line opcode, then four-bit address, mode, two dummy bytes.
// - Set burst is opcode plus one data cycle, in either protocol.
// - Burst code 0..3 selects 8, 16, 32, 64 bytes; default is 8.
// - Quad wrapped read: opcode, three address, three dummy cycles, then data.
// - Wrapped reads increment within the aligned burst window and loop.
// - Data streams until chip select rises, which ends the read.
// - Quad enable opcode switches all later framing to four bits.
`default_nettype none

module qfd_top
  import qfd_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe,
  // Configuration levels, system domain
  input wire logic io_configuration_bit,
  input wire logic [1:0] read_lock,
  // Array preload, system domain
  input wire logic mem_wr_en,
  input wire logic [MEM_AW-1:0] mem_wr_addr,
  input wire logic [MEM_DW-1:0] mem_wr_data,
  // Status, system domain
  output logic quad_io_protocol,
  output logic cont_read_active,
  output logic [1:0] burst_len_code,
  output logic read_active,
  output logic opcode_rejected
);

  // Reset synchroniser on the system clock
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Link resets: persistent state dies only with system reset, frame state with cs_b too
  wire link_rst_b;
  wire frame_rst_b;
  assign link_rst_b = rst_sync_ff;
  assign frame_rst_b = rst_sync_ff & ~cs_b;

  // Configuration levels into the serial domain; only settle while sck runs
  logic [2:0] cfg_meta_ff;
  logic [2:0] cfg_ff;

  always_ff @(posedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cfg_meta_ff <= 3'h0;
      cfg_ff <= 3'h0;
    end else begin
      cfg_meta_ff <= {read_lock, io_configuration_bit};
      cfg_ff <= cfg_meta_ff;
    end
  end

  wire ioc_ok_w;
  wire lock_bottom_w;
  wire lock_top_w;
  assign ioc_ok_w = cfg_ff[0];
  assign lock_bottom_w = cfg_ff[1];
  assign lock_top_w = cfg_ff[2];

  // Frame state, cleared whenever chip select is high; reject_tgl_ff only clears on system reset
  qfd_state_e state_ff;
  qfd_kind_e kind_ff;
  logic [4:0] cnt_ff;
  logic [23:0] sr_ff;
  logic [23:0] ptr_ff;
  logic [7:0] out_sr_ff;
  logic cont_frame_ff;
  logic reject_tgl_ff;

  // State that survives frames
  logic quad_mode_ff;
  logic cont_ff;
  qfd_kind_e cont_kind_ff;
  logic [1:0] burst_ff;

  // Next values
  qfd_state_e nxt_state;
  qfd_kind_e nxt_kind;
  logic [4:0] nxt_cnt;
  logic [23:0] nxt_ptr;
  logic [7:0] nxt_out_sr;
  logic nxt_quad_mode;
  logic nxt_cont;
  qfd_kind_e nxt_cont_kind;
  logic [1:0] nxt_burst;
  logic nxt_reject;

  // Continuous read: a fresh frame is read as if an opcode had already arrived
  wire cont_start_w;
  wire in_cont_frame_w;
  qfd_state_e st_w;
  qfd_kind_e kd_w;
  assign cont_start_w = (state_ff == ST_OPC) && cont_ff;
  assign in_cont_frame_w = cont_start_w | cont_frame_ff;
  assign st_w = cont_start_w ? ST_ADDR : state_ff;
  assign kd_w = cont_start_w ? cont_kind_ff : kind_ff;

  // Width of each phase: opcode and burst data follow the protocol, the rest the command
  wire framing_phase_w;
  wire kind_quad_in_w;
  wire quad_in_w;
  wire quad_out_w;
  wire has_mode_w;
  assign framing_phase_w = (st_w == ST_OPC) || (st_w == ST_BURST) || (st_w == ST_IGNORE);
  assign kind_quad_in_w = (kd_w == K_QIO) || (kd_w == K_HS_QUAD) || (kd_w == K_WRAP);
  assign quad_in_w = framing_phase_w ? quad_mode_ff : kind_quad_in_w;
  assign quad_out_w = (kd_w != K_HS_SINGLE);
  assign has_mode_w = (kd_w == K_QIO) || (kd_w == K_HS_QUAD);

  // Phase lengths in serial clocks
  wire [4:0] opc_len_w;
  wire [4:0] addr_len_w;
  wire [4:0] dummy_len_w;
  wire [4:0] byte_len_w;
  wire [4:0] phase_len_w;
  wire cnt_last_w;
  assign opc_len_w = quad_mode_ff ? OPC_CLKS_QUAD : OPC_CLKS_SINGLE;
  assign addr_len_w = quad_in_w ? ADDR_CLKS_QUAD : ADDR_CLKS_SINGLE;
  assign dummy_len_w = (kd_w == K_WRAP) ? DUMMY_CLKS_WRAP :
                       has_mode_w ? DUMMY_CLKS_QIO : DUMMY_CLKS_BYTE;
  assign byte_len_w = quad_out_w ? BYTE_CLKS_QUAD : BYTE_CLKS_SINGLE;
  assign phase_len_w = (st_w == ST_ADDR) ? addr_len_w :
                       (st_w == ST_MODE) ? MODE_CLKS :
                       (st_w == ST_DUMMY) ? dummy_len_w :
                       (st_w == ST_DATA) ? byte_len_w : opc_len_w;
  assign cnt_last_w = (cnt_ff == (phase_len_w - 5'h01));

  // Input assembly, most significant bit or nibble first; single mode reads sio_i[0] only
  wire [7:0] in_byte_w;
  wire [23:0] in_addr_w;
  assign in_byte_w = quad_in_w ? {sr_ff[3:0], sio_i} : {sr_ff[6:0], sio_i[0]};
  assign in_addr_w = quad_in_w ? {sr_ff[19:0], sio_i} : {sr_ff[22:0], sio_i[0]};

  // Opcode decode, legality depends on protocol and the I/O configuration bit
  wire opc_qreset_w;
  wire opc_qen_w;
  wire opc_burst_w;
  wire opc_hs_w;
  wire opc_qout_w;
  wire opc_qio_w;
  wire opc_wrap_w;
  assign opc_qreset_w = (in_byte_w == OPC_QUAD_RESET);
  assign opc_qen_w = (in_byte_w == OPC_QUAD_ENABLE) && !quad_mode_ff;
  assign opc_burst_w = (in_byte_w == OPC_SET_BURST);
  assign opc_hs_w = (in_byte_w == OPC_HS_READ);
  assign opc_qout_w = (in_byte_w == OPC_QOUT_READ) && !quad_mode_ff && ioc_ok_w;
  assign opc_qio_w = (in_byte_w == OPC_QIO_READ) && !quad_mode_ff && ioc_ok_w;
  assign opc_wrap_w = (in_byte_w == OPC_WRAP_READ) && quad_mode_ff;

  // A quad reset as first byte of a continued frame only drops continuous mode
  wire cont_exit_w;
  assign cont_exit_w = in_cont_frame_w && (cnt_ff == QUAD_FIRST_BYTE_LAST) &&
                       (in_byte_w == OPC_QUAD_RESET);

  // Read data: array byte unless the pointer sits in a read-locked block
  wire [MEM_DW-1:0] mem_rd_data_w;
  wire [10:0] blk_w;
  wire lock_hit_w;
  wire [7:0] data_byte_w;
  assign blk_w = ptr_ff[LOCK_MSB:LOCK_LSB];
  assign lock_hit_w = (lock_bottom_w && (blk_w == LOCK_BLK_BOTTOM)) ||
                      (lock_top_w && (blk_w == LOCK_BLK_TOP));
  assign data_byte_w = lock_hit_w ? 8'h00 : mem_rd_data_w;

  // Pointer advance: linear wraps through 24 bits, wrapped read stays in its window
  wire [23:0] wrap_len_w;
  wire [23:0] wrap_mask_w;
  wire [23:0] ptr_inc_w;
  wire [23:0] ptr_nxt_w;
  assign wrap_len_w = WRAP_BASE_LEN << burst_ff;
  assign wrap_mask_w = wrap_len_w - 24'h000001;
  assign ptr_inc_w = ptr_ff + 24'h000001;
  assign ptr_nxt_w = (kd_w == K_WRAP) ?
                     ((ptr_ff & ~wrap_mask_w) | (ptr_inc_w & wrap_mask_w)) :
                     ptr_inc_w;

  // Sequencer next-state; each phase but data and ignore ends on its last clock, except an address phase cut short by a continued-frame quad reset
  always_comb begin
    nxt_state = st_w;
    nxt_kind = kd_w;
    nxt_cnt = cnt_last_w ? 5'h00 : (cnt_ff + 5'h01);
    nxt_ptr = ptr_ff;
    nxt_out_sr = out_sr_ff;
    nxt_quad_mode = quad_mode_ff;
    nxt_cont = cont_ff;
    nxt_cont_kind = cont_kind_ff;
    nxt_burst = burst_ff;
    nxt_reject = reject_tgl_ff;
    case (st_w)
      ST_OPC: begin
        if (cnt_last_w) begin
          nxt_state = ST_IGNORE;
          if (opc_qreset_w) begin
            nxt_quad_mode = 1'b0;
            nxt_cont = 1'b0;
          end else if (opc_qen_w) begin
            nxt_quad_mode = 1'b1;
          end else if (opc_burst_w) begin
            nxt_state = ST_BURST;
          end else if (opc_hs_w) begin
            nxt_state = ST_ADDR;
            nxt_kind = quad_mode_ff ? K_HS_QUAD : K_HS_SINGLE;
          end else if (opc_qout_w) begin
            nxt_state = ST_ADDR;
            nxt_kind = K_QOUT;
          end else if (opc_qio_w) begin
            nxt_state = ST_ADDR;
            nxt_kind = K_QIO;
          end else if (opc_wrap_w) begin
            nxt_state = ST_ADDR;
            nxt_kind = K_WRAP;
          end else begin
            nxt_reject = ~reject_tgl_ff;
          end
        end
      end
      ST_ADDR: begin
        if (cont_exit_w) begin
          nxt_cont = 1'b0;
          nxt_state = ST_IGNORE;
        end else if (cnt_last_w) begin
          nxt_ptr = in_addr_w;
          nxt_state = has_mode_w ? ST_MODE : ST_DUMMY;
        end
      end
      ST_MODE: begin
        if (cnt_last_w) begin
          nxt_cont = (in_byte_w[7:4] == CONT_NIBBLE);
          nxt_cont_kind = kd_w;
          nxt_state = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (cnt_last_w) begin
          nxt_state = ST_DATA;
          nxt_out_sr = data_byte_w;
          nxt_ptr = ptr_nxt_w;
        end
      end
      ST_DATA: begin
        // Stays here until chip select rises and clears the frame
        if (cnt_last_w) begin
          nxt_out_sr = data_byte_w;
          nxt_ptr = ptr_nxt_w;
        end else if (quad_out_w) begin
          nxt_out_sr = {out_sr_ff[3:0], 4'h0};
        end else begin
          nxt_out_sr = {out_sr_ff[6:0], 1'b0};
        end
      end
      ST_BURST: begin
        if (cnt_last_w) begin
          nxt_state = ST_IGNORE;
          if (in_byte_w[7:2] == 6'h00) begin
            nxt_burst = in_byte_w[1:0];
          end
        end
      end
      ST_IGNORE: begin
        nxt_cnt = cnt_ff;
      end
      default: begin
        nxt_state = ST_IGNORE;
      end
    endcase
  end

  // Frame registers, sampled on the rising serial edge
  always_ff @(posedge sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      state_ff <= ST_OPC;
      kind_ff <= K_HS_SINGLE;
      cnt_ff <= 5'h00;
      sr_ff <= 24'h000000;
      ptr_ff <= 24'h000000;
      out_sr_ff <= 8'h00;
      cont_frame_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      sr_ff <= in_addr_w;
      ptr_ff <= nxt_ptr;
      out_sr_ff <= nxt_out_sr;
      cont_frame_ff <= in_cont_frame_w;
    end
  end

  // Persistent registers; the cs_b guard keeps stray idle clocks harmless
  always_ff @(posedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      quad_mode_ff <= 1'b0;
      cont_ff <= 1'b0;
      cont_kind_ff <= K_HS_QUAD;
      burst_ff <= BURST_RST;
      reject_tgl_ff <= 1'b0;
    end else if (!cs_b) begin
      quad_mode_ff <= nxt_quad_mode;
      cont_ff <= nxt_cont;
      cont_kind_ff <= nxt_cont_kind;
      burst_ff <= nxt_burst;
      reject_tgl_ff <= nxt_reject;
    end
  end

  // Output stage on the falling edge so data is stable for the host's rising sample
  wire drive_w;
  wire [3:0] nxt_sio_o;
  wire [3:0] nxt_sio_oe;
  logic [3:0] sio_o_ff;
  logic [3:0] sio_oe_ff;
  assign drive_w = (state_ff == ST_DATA);
  assign nxt_sio_o = quad_out_w ? out_sr_ff[7:4] : {2'h0, out_sr_ff[7], 1'b0};
  assign nxt_sio_oe = !drive_w ? OE_NONE : (quad_out_w ? OE_QUAD : OE_SINGLE);

  always_ff @(negedge sck or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      sio_o_ff <= 4'h0;
      sio_oe_ff <= OE_NONE;
    end else begin
      sio_o_ff <= nxt_sio_o;
      sio_oe_ff <= nxt_sio_oe;
    end
  end

  assign sio_o = sio_o_ff;
  assign sio_oe = sio_oe_ff;

  // Status back to the system clock; burst code is quasi-static, so bitwise sync is enough
  wire [5:0] stat_src_w;
  logic [5:0] stat_meta_ff;
  logic [5:0] stat_ff;
  logic reject_d_ff;
  logic opcode_rejected_ff;
  assign stat_src_w = {reject_tgl_ff, drive_w, burst_ff, cont_ff, quad_mode_ff};

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      stat_meta_ff <= 6'h00;
      stat_ff <= 6'h00;
      reject_d_ff <= 1'b0;
      opcode_rejected_ff <= 1'b0;
    end else begin
      stat_meta_ff <= stat_src_w;
      stat_ff <= stat_meta_ff;
      reject_d_ff <= stat_ff[5];
      opcode_rejected_ff <= stat_ff[5] ^ reject_d_ff;
    end
  end

  assign quad_io_protocol = stat_ff[0];
  assign cont_read_active = stat_ff[1];
  assign burst_len_code = stat_ff[3:2];
  assign read_active = stat_ff[4];
  assign opcode_rejected = opcode_rejected_ff;

  // Backing array
  qfd_mem u_mem (
    .wr_clk(clk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_clk(sck),
    .rd_addr(ptr_ff[MEM_AW-1:0]),
    .rd_data(mem_rd_data_w)
  );

endmodule

`default_nettype wire

// *** hw/qfd_pkg.sv ***
// Shared constants and types for the quad read command decoder.
// Assumes a single-clock system side plus a link side clocked by the serial clock.
`default_nettype none

package qfd_pkg;

  // Opcodes recognised by the decoder
  localparam logic [7:0] OPC_HS_READ = 8'h0b;
  localparam logic [7:0] OPC_QOUT_READ = 8'h6b;
  localparam logic [7:0] OPC_QIO_READ = 8'heb;
  localparam logic [7:0] OPC_WRAP_READ = 8'h0c;
  localparam logic [7:0] OPC_SET_BURST = 8'hc0;
  localparam logic [7:0] OPC_QUAD_RESET = 8'hff;
  localparam logic [7:0] OPC_QUAD_ENABLE = 8'h38;

  // Upper nibble of the mode byte that keeps continuous-read mode
  localparam logic [3:0] CONT_NIBBLE = 4'ha;

  // Serial clock counts of each phase
  localparam logic [4:0] OPC_CLKS_SINGLE = 5'h08;
  localparam logic [4:0] OPC_CLKS_QUAD = 5'h02;
  localparam logic [4:0] ADDR_CLKS_SINGLE = 5'h18;
  localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
  localparam logic [4:0] MODE_CLKS = 5'h02;
  localparam logic [4:0] DUMMY_CLKS_BYTE = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_QIO = 5'h04;
  localparam logic [4:0] DUMMY_CLKS_WRAP = 5'h06;
  localparam logic [4:0] BYTE_CLKS_SINGLE = 5'h08;
  localparam logic [4:0] BYTE_CLKS_QUAD = 5'h02;
  localparam logic [4:0] QUAD_FIRST_BYTE_LAST = 5'h01;

  // Burst length code and wrap window
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [23:0] WRAP_BASE_LEN = 24'h000008;

  // Read-locked parameter blocks, selected by address bits 23..13
  localparam int LOCK_MSB = 23;
  localparam int LOCK_LSB = 13;
  localparam logic [10:0] LOCK_BLK_BOTTOM = 11'h000;
  localparam logic [10:0] LOCK_BLK_TOP = 11'h7ff;

  // Output enables per data width
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hf;

  // Backing array geometry
  localparam int MEM_AW = 8;
  localparam int MEM_DW = 8;

  // Frame phases
  typedef enum logic [2:0] {
    ST_OPC,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_BURST,
    ST_IGNORE
  } qfd_state_e;

  // Read flavours
  typedef enum logic [2:0] {
    K_HS_SINGLE,
    K_QOUT,
    K_QIO,
    K_HS_QUAD,
    K_WRAP
  } qfd_kind_e;

endpackage

`default_nettype wire

// *** hw/qfd_mem.sv ***
// Small byte array standing in for the flash cells.
// Written from the system clock, read from the serial clock; read data is registered.
`default_nettype none

module qfd_mem
  import qfd_pkg::*;
(
  // Write side
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [MEM_DW-1:0] wr_data,
  // Read side
  input wire logic rd_clk,
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [MEM_DW-1:0] rd_data
);

  logic [MEM_DW-1:0] mem_ff [0:(1<<MEM_AW)-1];
  logic [MEM_DW-1:0] rd_data_ff;

  // Preload port; no reset so it maps onto block memory
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Reads every rising serial edge; the decoder keeps the address steady ahead of use
  always_ff @(posedge rd_clk) begin
    rd_data_ff <= mem_ff[rd_addr];
  end

  assign rd_data = rd_data_ff;

endmodule

`default_nettype wire

// *** dv/qfd_top_monitor.sv ***
// Port-level assertions for the quad read decoder, all sampled on the system clock.
// Assumes sck runs far slower than clk, so link levels settle between samples.
`default_nettype none

module qfd_top_monitor
  import qfd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] sio_o,
  input wire logic [3:0] sio_oe,
  // Status
  input wire logic quad_io_protocol,
  input wire logic [1:0] burst_len_code,
  input wire logic read_active,
  input wire logic opcode_rejected
);
  // One domain only, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Deselected long enough for the lagging status flag to follow
  sequence s_deselected;
    cs_b [*6];
  endsequence

  // Device driving data inside a frame
  sequence s_streaming;
    (!cs_b && sio_oe != OE_NONE) [*5];
  endsequence

  a_oe_legal: assert property (
    sio_oe == OE_NONE || sio_oe == OE_SINGLE || sio_oe == OE_QUAD)
    else $error("output enable pattern not allowed");
  a_idle_quiet: assert property (cs_b |-> sio_oe == OE_NONE)
    else $error("lines driven while deselected");
  a_oe_steady: assert property (
    !cs_b && $past(!cs_b) && $past(sio_oe) != OE_NONE |-> $stable(sio_oe))
    else $error("output enable changed inside a read");
  a_data_falling: assert property ($changed(sio_o) |-> !sck || cs_b)
    else $error("data changed while sck high");
  a_rej_pulse: assert property (opcode_rejected |=> !opcode_rejected)
    else $error("reject flag longer than one cycle");
  a_rej_silent: assert property (
    opcode_rejected && !cs_b |-> sio_oe == OE_NONE)
    else $error("output driven after ignored opcode");
  a_read_flag: assert property (s_streaming |-> read_active)
    else $error("read flag low while streaming");
  a_idle_flag: assert property (s_deselected |-> !read_active)
    else $error("read flag high after deselect");
  a_reset_dflt: assert property (
    $rose(rst_b) |-> burst_len_code == BURST_RST && !quad_io_protocol)
    else $error("defaults wrong after reset");
endmodule

bind qfd_top qfd_top_monitor u_mon (
  .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .sio_o(sio_o), .sio_oe(sio_oe),
  .quad_io_protocol(quad_io_protocol), .burst_len_code(burst_len_code),
  .read_active(read_active), .opcode_rejected(opcode_rejected)
);

`default_nettype wire

// *** dv/qfd_host.sv ***
// Host controller model: frames chip select, runs sck only in frames, shifts and samples.
// Assumes the bench resolves the shared data lines from the device's enables.
`default_nettype none

module qfd_host (
  // System clock, only used to place frames
  input wire logic clk,
  // Link pins
  output logic sck,
  output logic cs_b,
  output logic [3:0] h_o,
  input wire logic [3:0] sio
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] last_v;

  // Idle: deselected, clock parked low
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    last_v = 4'h0;
    h_o = 4'hf;
  end

  // Offset keeps sck edges off the system clock grid
  task automatic open_frame();
    @(posedge clk);
    #1.3 cs_b = 1'b0;
    #24;
  endtask

  // MSB first; single framing keeps the upper lines at a defined level
  task automatic put(input logic [31:0] v, input int n, input bit q);
    for (int i = n; i > 0; i -= (q ? 4 : 1)) begin
      last_v = q ? v[i-1 -: 4] : {3'h5, v[i-1]};
      h_o = last_v;
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask

  // Released lines toggle so a stale value never looks valid
  task automatic get(input bit q, output logic [7:0] b);
    h_o = ~last_v;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      #24 sck = 1'b1;
      b = q ? {b[3:0], sio} : {b[6:0], sio[1]};
      h_o = ~h_o;
      #24 sck = 1'b0;
    end
  endtask

  task automatic close_frame();
    #24 cs_b = 1'b1;
    h_o = ~last_v;
    #48;
  endtask
endmodule

`default_nettype wire

// *** dv/qfd_top_tb.sv ***
// Self-checking bench for the quad read decoder: table of reads, then hand-written cases.
// Assumes qfd_host plays the controller; the bench resolves the shared data lines.
`default_nettype none

module qfd_top_tb;
  import qfd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIMIT = 60000;
  typedef struct {logic [7:0] op; logic [23:0] a; logic [7:0] m; int n;} qfd_row_s;
  qfd_row_s rows [4] = '{
    '{OPC_HS_READ, 24'h000010, 8'h00, 3},
    '{OPC_HS_READ, 24'hffffff, 8'h00, 2},
    '{OPC_QOUT_READ, 24'h1234fe, 8'h00, 3},
    '{OPC_QIO_READ, 24'h0a0b0c, 8'h00, 2}};
  logic clk, rst_b, sck, cs_b, qp, cra, ra, rej;
  logic io_bit = 1'b1;
  logic mem_wr_en = 1'b0;
  logic [1:0] lock = 2'h0;
  logic [1:0] blc;
  logic [7:0] wa = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [3:0] sio_o, sio_oe, h_o, sio;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int rej_cnt = 0;
  int bset = 0;

  // Wire level: device wins where it enables, host elsewhere
  assign sio = (sio_oe & sio_o) | (~sio_oe & h_o);

  qfd_top dut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .sio_i(sio), .sio_o(sio_o),
    .sio_oe(sio_oe), .io_configuration_bit(io_bit), .read_lock(lock), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(wa), .mem_wr_data(wd), .quad_io_protocol(qp), .cont_read_active(cra),
    .burst_len_code(blc), .read_active(ra), .opcode_rejected(rej));
  qfd_host host (.clk(clk), .sck(sck), .cs_b(cs_b), .h_o(h_o), .sio(sio));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle ceiling and reject pulse counting
  always @(posedge clk) begin
    cyc++;
    if (rej === 1'b1) rej_cnt++;
    if (cyc == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [7:0] pat(input logic [23:0] a);
    return {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %0h got %0h", nm, e, g);
      miscompares++;
    end
  endtask

  // Status outputs lag the link side by a few clocks
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  // One read frame; framing follows the opcode, protocol and continuation
  task automatic rd(input logic [7:0] op, input bit q, input bit cont, input logic [23:0] a,
                    input logic [7:0] m, input int n);
    logic [7:0] b;
    logic [23:0] ea, wm;
    bit aq, dq, lk;
    aq = q || cont || op == OPC_QIO_READ;
    dq = aq || op == OPC_QOUT_READ;
    wm = 24'((8 << bset) - 1);
    host.open_frame();
    if (!cont) host.put({24'h0, op}, 8, q);
    host.put({8'h0, a}, 24, aq);
    if (aq && op != OPC_WRAP_READ) host.put({24'h0, m}, 8, 1'b1);
    host.put(32'h0, op == OPC_WRAP_READ ? 24 : (aq ? 16 : 8), aq);
    for (int i = 0; i < n; i++) begin
      host.get(dq, b);
      ea = op == OPC_WRAP_READ ? (a & ~wm) | ((a + 24'(i)) & wm) : a + 24'(i);
      lk = (lock[0] && ea[23:13] == LOCK_BLK_BOTTOM) || (lock[1] && ea[23:13] == LOCK_BLK_TOP);
      chk("data", lk ? 8'h00 : pat(ea), b);
      if (i == 0) chk("oe", dq ? OE_QUAD : OE_SINGLE, sio_oe);
    end
    host.close_frame();
    settle();
  endtask

  task automatic cmd(input logic [7:0] op, input bit q, input bit hd, input logic [7:0] d);
    host.open_frame();
    host.put({24'h0, op}, 8, q);
    if (hd) host.put({24'h0, d}, 8, q);
    host.close_frame();
    settle();
  endtask

  // An ignored opcode gives no output and one reject pulse
  task automatic rj(input logic [7:0] op, input bit q);
    int k;
    logic [7:0] b;
    k = rej_cnt;
    host.open_frame();
    host.put({24'h0, op}, 8, q);
    repeat (2) host.get(1'b0, b);
    chk("rej_oe", OE_NONE, sio_oe);
    host.close_frame();
    settle();
    chk("rej_cnt", k + 1, rej_cnt);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    // Preload the array with an address-derived pattern
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      #1 mem_wr_en = 1'b1;
      wa = 8'(i);
      wd = pat(24'(i));
    end
    @(posedge clk);
    #1 mem_wr_en = 1'b0;
    foreach (rows[r]) begin
      rd(rows[r].op, 1'b0, 1'b0, rows[r].a, rows[r].m, rows[r].n);
    end
    $display("test rows done");
    rj(OPC_WRAP_READ, 1'b0);
    rj(8'h5a, 1'b0);
    io_bit = 1'b0;
    rj(OPC_QOUT_READ, 1'b0);
    io_bit = 1'b1;
    $display("test reject done");
    cmd(OPC_SET_BURST, 1'b0, 1'b1, 8'h02);
    bset = 2;
    chk("burst", 2, blc);
    cmd(OPC_QUAD_ENABLE, 1'b0, 1'b0, 8'h00);
    chk("quad", 1, qp);
    rj(OPC_QUAD_ENABLE, 1'b1);
    rj(OPC_QIO_READ, 1'b1);
    for (int c = 0; c < 4; c++) begin
      cmd(OPC_SET_BURST, 1'b1, 1'b1, 8'(c));
      bset = c;
      chk("burst", c, blc);
      rd(OPC_WRAP_READ, 1'b1, 1'b0, 24'h3c4d5e, 8'h00, (8 << c) + 2);
    end
    cmd(OPC_SET_BURST, 1'b1, 1'b1, 8'h04);
    chk("burst_bad", 3, blc);
    $display("test burst done");
    lock = 2'h3;
    // Top-block address goes in the opcode frame: a continued frame opening with ff exits
    rd(OPC_HS_READ, 1'b1, 1'b0, 24'hfffffe, 8'ha5, 4);
    chk("cont_on", 1, cra);
    rd(OPC_HS_READ, 1'b1, 1'b1, 24'h001ffe, 8'h5a, 4);
    chk("cont_off", 0, cra);
    lock = 2'h0;
    rd(OPC_HS_READ, 1'b1, 1'b0, 24'h000040, 8'ha0, 1);
    chk("cont_on", 1, cra);
    cmd(OPC_QUAD_RESET, 1'b1, 1'b0, 8'h00);
    chk("cont_rst", 0, cra);
    chk("quad_kept", 1, qp);
    cmd(OPC_QUAD_RESET, 1'b1, 1'b0, 8'h00);
    chk("quad_rst", 0, qp);
    cmd(OPC_QUAD_RESET, 1'b0, 1'b0, 8'h00);
    chk("single", 0, qp);
    rd(OPC_QIO_READ, 1'b0, 1'b0, 24'h00aa55, 8'ha3, 2);
    chk("cont_on", 1, cra);
    rd(OPC_QIO_READ, 1'b0, 1'b1, 24'h00017f, 8'h00, 2);
    chk("cont_off", 0, cra);
    $display("test continuous done");
    cmd(OPC_QUAD_ENABLE, 1'b0, 1'b0, 8'h00);
    cmd(OPC_SET_BURST, 1'b1, 1'b1, 8'h01);
    chk("pre_quad", 1, qp);
    chk("pre_burst", 1, blc);
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    settle();
    chk("rst_quad", 0, qp);
    chk("rst_burst", 0, blc);
    bset = 0;
    rd(OPC_HS_READ, 1'b0, 1'b0, 24'h000123, 8'h00, 2);
    $display("test reset done");
    stop_test();
  end
endmodule

`default_nettype wire
